// >>> core/dmo_operand_router.sv
// Dual-MAC operand routing: pointer file, three read buses, two MAC units
`include "dmo_consts.svh"

module dmo_operand_router #(
    parameter int                   DATA_W      = `DMO_DATA_W,
    parameter int                   ACC_W       = `DMO_ACC_W,
    parameter int                   PTR_W       = `DMO_PTR_W,
    parameter logic [`DMO_PTR_W-1:0] INT_MEM_TOP = `DMO_INT_MEM_TOP
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    // Mode bit of status_word_2, low selects DSP addressing
    input  wire logic                      addr_mode_arms,
    // Dual operation request
    input  wire logic                      op_valid,
    input  wire dmo_pkg::dmo_op_t          op_kind,
    input  wire logic [`DMO_SEL_W-1:0]     op_first_sel,
    input  wire logic [`DMO_SEL_W-1:0]     op_second_sel,
    input  wire logic [PTR_W-1:0]          op_first_step,
    input  wire logic [PTR_W-1:0]          op_second_step,
    input  wire logic [PTR_W-1:0]          op_coef_step,
    // Pointer load
    input  wire logic                      ptr_wr,
    input  wire logic [`DMO_IDX_W-1:0]     ptr_wr_idx,
    input  wire logic [PTR_W-1:0]          ptr_wr_data,
    // Shared coefficient read bus
    output logic                           shared_coef_bus_rd_q,
    output logic [PTR_W-1:0]               shared_coef_bus_addr_q,
    input  wire logic [DATA_W-1:0]         shared_coef_bus_data,
    // First operand read bus
    output logic                           first_operand_bus_rd_q,
    output logic [PTR_W-1:0]               first_operand_bus_addr_q,
    input  wire logic [DATA_W-1:0]         first_operand_bus_data,
    // Second operand read bus
    output logic                           second_operand_bus_rd_q,
    output logic [PTR_W-1:0]               second_operand_bus_addr_q,
    input  wire logic [DATA_W-1:0]         second_operand_bus_data,
    // Results and status
    output logic [ACC_W-1:0]               accumulator_0_q,
    output logic [ACC_W-1:0]               accumulator_1_q,
    output logic                           result_valid_q,
    output logic                           op_refused_q,
    output logic [PTR_W-1:0]               coefficient_pointer_q
);

    ////////////////////////////////////////////////////////////////////////////
    // Pointer file

    logic [PTR_W-1:0]       aux_pointer_q [`DMO_NUM_AUX];
    logic [PTR_W-1:0]       coef_ptr_q;
    logic [PTR_W-1:0]       first_ptr;
    logic [PTR_W-1:0]       second_ptr;
    logic                   coef_internal;
    logic                   accept;
    logic                   refuse;
    dmo_pkg::dmo_op_t       kind_q;

    assign first_ptr     = aux_pointer_q[op_first_sel];
    assign second_ptr    = aux_pointer_q[op_second_sel];
    // External space would hang the shared bus, so refuse rather than issue
    assign coef_internal = coef_ptr_q < INT_MEM_TOP;
    assign accept        = op_valid && !addr_mode_arms && coef_internal;
    assign refuse        = op_valid && !accept;

    // Load wins over post-modify on the same pointer
    for (genvar i = 0; i < `DMO_NUM_AUX; i++) begin : g_aux
        logic [PTR_W-1:0] step_sum;
        always_comb begin
            step_sum = '0;
            if (op_first_sel == i[`DMO_SEL_W-1:0]) begin
                step_sum = step_sum + op_first_step;
            end
            if (op_second_sel == i[`DMO_SEL_W-1:0]) begin
                step_sum = step_sum + op_second_step;
            end
        end
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                aux_pointer_q[i] <= '0;
            end else if (ptr_wr && ptr_wr_idx == i[`DMO_IDX_W-1:0]) begin
                aux_pointer_q[i] <= ptr_wr_data;
            end else if (accept) begin
                aux_pointer_q[i] <= aux_pointer_q[i] + step_sum;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            coef_ptr_q <= '0;
        end else if (ptr_wr && ptr_wr_idx == `DMO_COEF_IDX) begin
            coef_ptr_q <= ptr_wr_data;
        end else if (accept) begin
            coef_ptr_q <= coef_ptr_q + op_coef_step;
        end
    end

    assign coefficient_pointer_q = coef_ptr_q;

    ////////////////////////////////////////////////////////////////////////////
    // Read issue: all three buses in the same cycle

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shared_coef_bus_rd_q    <= 1'b0;
            first_operand_bus_rd_q  <= 1'b0;
            second_operand_bus_rd_q <= 1'b0;
        end else begin
            shared_coef_bus_rd_q    <= accept;
            first_operand_bus_rd_q  <= accept;
            second_operand_bus_rd_q <= accept;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shared_coef_bus_addr_q    <= '0;
            first_operand_bus_addr_q  <= '0;
            second_operand_bus_addr_q <= '0;
            kind_q                    <= dmo_pkg::OP_MPY;
        end else if (accept) begin
            shared_coef_bus_addr_q    <= coef_ptr_q;
            first_operand_bus_addr_q  <= first_ptr;
            second_operand_bus_addr_q <= second_ptr;
            kind_q                    <= op_kind;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op_refused_q   <= 1'b0;
            result_valid_q <= 1'b0;
        end else begin
            op_refused_q   <= refuse;
            result_valid_q <= shared_coef_bus_rd_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // MAC units: read data is taken in the same cycle as the strobe

    dmo_mac_if #(.DATA_W(DATA_W), .ACC_W(ACC_W)) mac_bus [2] ();
    logic [ACC_W-1:0] acc_w [2];

    for (genvar g = 0; g < 2; g++) begin : g_mac
        assign mac_bus[g].en      = shared_coef_bus_rd_q;
        assign mac_bus[g].kind    = kind_q;
        assign mac_bus[g].coef    = shared_coef_bus_data;
        assign mac_bus[g].operand = (g == 0) ? first_operand_bus_data : second_operand_bus_data;
        assign acc_w[g]           = mac_bus[g].acc;
        dmo_mac_unit #(.DATA_W(DATA_W), .ACC_W(ACC_W)) u_mac (
            .clk (clk),
            .rst (rst),
            .mac (mac_bus[g])
        );
    end

    assign accumulator_0_q = acc_w[0];
    assign accumulator_1_q = acc_w[1];

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic signed [2*DATA_W-1:0] prod1;
    assign prod1 = $signed(shared_coef_bus_data) * $signed(second_operand_bus_data);

    property p_three_reads;
        accept |=> shared_coef_bus_rd_q && first_operand_bus_rd_q && second_operand_bus_rd_q;
    endproperty
    a_three_reads: assert property (p_three_reads)
        else $error("Accepted operation did not strobe all three buses");

    property p_both_results;
        accept |=> ##1 result_valid_q;
    endproperty
    a_both_results: assert property (p_both_results)
        else $error("Dual operation did not complete two cycles later");

    property p_shared_coef;
        shared_coef_bus_rd_q && kind_q == dmo_pkg::OP_MPY
            |=> accumulator_1_q == {{(ACC_W-2*DATA_W){$past(prod1[2*DATA_W-1])}}, $past(prod1)};
    endproperty
    a_shared_coef: assert property (p_shared_coef)
        else $error("Second unit did not use the shared coefficient");

    property p_coef_load;
        ptr_wr && ptr_wr_idx == `DMO_COEF_IDX |=> coef_ptr_q == $past(ptr_wr_data);
    endproperty
    a_coef_load: assert property (p_coef_load)
        else $error("Coefficient pointer load lost");

    property p_aux_addr;
        accept |=> first_operand_bus_addr_q == $past(first_ptr) && second_operand_bus_addr_q == $past(second_ptr);
    endproperty
    a_aux_addr: assert property (p_aux_addr)
        else $error("Operand address not from the selected auxiliary pointer");

    property p_coef_addr;
        accept |=> shared_coef_bus_addr_q == $past(coef_ptr_q);
    endproperty
    a_coef_addr: assert property (p_coef_addr)
        else $error("Shared bus address not from the coefficient pointer");

    property p_internal_only;
        shared_coef_bus_rd_q |-> shared_coef_bus_addr_q < INT_MEM_TOP;
    endproperty
    a_internal_only: assert property (p_internal_only)
        else $error("Shared bus issued an external address");

    property p_mode_gate;
        op_valid && addr_mode_arms |=> op_refused_q && !first_operand_bus_rd_q;
    endproperty
    a_mode_gate: assert property (p_mode_gate)
        else $error("Operation ran outside DSP addressing mode");

    property p_same_cycle;
        result_valid_q |-> $past(mac_bus[0].en) && $past(mac_bus[1].en);
    endproperty
    a_same_cycle: assert property (p_same_cycle)
        else $error("Units did not compute in the same cycle");

    c_accept:  cover property (accept ##2 result_valid_q);
    c_refuse:  cover property (refuse ##1 op_refused_q);
    c_b2b:     cover property (accept ##1 accept ##1 accept);
    c_mas:     cover property (accept && op_kind == dmo_pkg::OP_MAS);

endmodule : dmo_operand_router

// >>> core/dmo_consts.svh
// Widths, pointer indices and limits for the dual-MAC operand router
`ifndef DMO_CONSTS_SVH
`define DMO_CONSTS_SVH

`define DMO_DATA_W      16
`define DMO_ACC_W       40
`define DMO_PTR_W       24
`define DMO_NUM_AUX     8
`define DMO_SEL_W       3
`define DMO_IDX_W       4
`define DMO_COEF_IDX    4'h8
`define DMO_INT_MEM_TOP 24'h050000
`define DMO_RD_LATENCY  1

`endif

// >>> core/dmo_pkg.sv
// Types shared by the dual-MAC operand router and its MAC units
package dmo_pkg;

    typedef enum logic [1:0] {
        OP_MPY,
        OP_MAC,
        OP_MAS
    } dmo_op_t;

endpackage : dmo_pkg

// >>> core/dmo_mac_if.sv
// Operand feed from the router into one MAC unit, accumulator back
interface dmo_mac_if #(
    parameter int DATA_W = 16,
    parameter int ACC_W  = 40
);
    logic                 en;
    dmo_pkg::dmo_op_t     kind;
    logic [DATA_W-1:0]    coef;
    logic [DATA_W-1:0]    operand;
    logic [ACC_W-1:0]     acc;

    modport feed (output en, output kind, output coef, output operand, input acc);
    modport unit (input en, input kind, input coef, input operand, output acc);
endinterface : dmo_mac_if

// >>> core/dmo_mac_unit.sv
// One multiply-accumulate unit with its own destination accumulator
`include "dmo_consts.svh"

module dmo_mac_unit #(
    parameter int DATA_W = `DMO_DATA_W,
    parameter int ACC_W  = `DMO_ACC_W
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Operand feed
    dmo_mac_if.unit   mac
);

    logic signed [2*DATA_W-1:0] prod;
    logic        [ACC_W-1:0]    prod_ext;
    logic        [ACC_W-1:0]    acc_q;

    assign prod     = $signed(mac.coef) * $signed(mac.operand);
    assign prod_ext = {{(ACC_W-2*DATA_W){prod[2*DATA_W-1]}}, prod};
    assign mac.acc  = acc_q;

    // Only this unit writes this accumulator
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_q <= '0;
        end else if (mac.en) begin
            case (mac.kind)
                dmo_pkg::OP_MPY: acc_q <= prod_ext;
                dmo_pkg::OP_MAC: acc_q <= acc_q + prod_ext;
                dmo_pkg::OP_MAS: acc_q <= acc_q - prod_ext;
                default:         acc_q <= acc_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_mac_accumulates;
        mac.en && mac.kind == dmo_pkg::OP_MAC |=> acc_q == $past(acc_q) + $past(prod_ext);
    endproperty
    a_mac_accumulates: assert property (p_mac_accumulates)
        else $error("Accumulate did not add the product");

    property p_idle_holds;
        !mac.en |=> $stable(acc_q);
    endproperty
    a_idle_holds: assert property (p_idle_holds)
        else $error("Accumulator changed without an operation");

endmodule : dmo_mac_unit

// >>> dv/dmo_mem_model.sv
// Behavioural data memory answering the three operand read buses
`include "dmo_consts.svh"

module dmo_mem_model #(
    parameter logic [`DMO_PTR_W-1:0] INT_MEM_TOP = `DMO_INT_MEM_TOP
) (
    // Clock
    input  wire logic                  clk,
    // Shared coefficient bus
    input  wire logic                  coef_rd,
    input  wire logic [`DMO_PTR_W-1:0] coef_addr,
    output logic      [`DMO_DATA_W-1:0] coef_data,
    // First operand bus
    input  wire logic                  first_rd,
    input  wire logic [`DMO_PTR_W-1:0] first_addr,
    output logic      [`DMO_DATA_W-1:0] first_data,
    // Second operand bus
    input  wire logic                  second_rd,
    input  wire logic [`DMO_PTR_W-1:0] second_addr,
    output logic      [`DMO_DATA_W-1:0] second_data
);
    timeunit 1ns;
    timeprecision 1ps;
    int ext_hits = 0;

    // Content depends on bus too, so a swapped bus shows up
    function automatic logic [15:0] word(input logic [23:0] a, input logic [1:0] bus);
        return (a[15:0] * 16'h0fb3) ^ {bus, 14'h12a5};
    endfunction : word

    ////////////////////////////////////////////////////////////////
    // Outside a strobe the bus shows the inverse, never stale data
    always_comb coef_data = coef_rd ? word(coef_addr, 2'h0) : ~word(coef_addr, 2'h0);
    always_comb first_data = first_rd ? word(first_addr, 2'h1) : ~word(first_addr, 2'h1);
    always_comb second_data = second_rd ? word(second_addr, 2'h2) : ~word(second_addr, 2'h2);

    ////////////////////////////////////////////////////////////////
    // Shared bus has no path to external memory
    always @(posedge clk) begin
        if (coef_rd && coef_addr >= INT_MEM_TOP) begin
            ext_hits <= ext_hits + 1;
        end
    end
endmodule : dmo_mem_model

// >>> dv/test_dual_mac_operand_routing.sv
// Self-checking bench for the dual-MAC operand router
`include "dmo_consts.svh"

module test_dual_mac_operand_routing;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic        refused;
        logic [23:0] fa, sa, ca;
        logic [39:0] a0, a1;
    } dmo_note_t;
    logic clk = 1'b0, rst = 1'b1, arms = 1'b0, op_valid = 1'b0, ptr_wr = 1'b0;
    dmo_pkg::dmo_op_t kind = dmo_pkg::OP_MPY;
    logic [2:0]  fsel = 3'h0, ssel = 3'h0;
    logic [3:0]  widx = 4'h0;
    logic [23:0] fstep = 24'h0, sstep = 24'h0, cstep = 24'h0, wdata = 24'h0;
    logic        c_rd, f_rd, s_rd, res_v, refused;
    logic [23:0] c_addr, f_addr, s_addr, cptr;
    logic [15:0] c_data, f_data, s_data;
    logic [39:0] acc0, acc1, m0 = 40'h0, m1 = 40'h0;
    logic [23:0] p [9];
    // Paired results land as one double-width store, two words apart
    logic [23:0] st_addr = 24'h0;
    dmo_note_t   q [$];
    int          miscompares = 0, check_count = 0;

    always #5 clk = ~clk;

    dmo_operand_router DUT (.clk(clk), .rst(rst), .addr_mode_arms(arms), .op_valid(op_valid), .op_kind(kind),
        .op_first_sel(fsel), .op_second_sel(ssel), .op_first_step(fstep), .op_second_step(sstep),
        .op_coef_step(cstep), .ptr_wr(ptr_wr), .ptr_wr_idx(widx), .ptr_wr_data(wdata),
        .shared_coef_bus_rd_q(c_rd), .shared_coef_bus_addr_q(c_addr), .shared_coef_bus_data(c_data),
        .first_operand_bus_rd_q(f_rd), .first_operand_bus_addr_q(f_addr), .first_operand_bus_data(f_data),
        .second_operand_bus_rd_q(s_rd), .second_operand_bus_addr_q(s_addr), .second_operand_bus_data(s_data),
        .accumulator_0_q(acc0), .accumulator_1_q(acc1), .result_valid_q(res_v), .op_refused_q(refused),
        .coefficient_pointer_q(cptr));

    dmo_mem_model mem (.clk(clk), .coef_rd(c_rd), .coef_addr(c_addr), .coef_data(c_data),
        .first_rd(f_rd), .first_addr(f_addr), .first_data(f_data),
        .second_rd(s_rd), .second_addr(s_addr), .second_data(s_data));

    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        if (miscompares == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    function automatic logic [39:0] acc_next(input logic [39:0] old, input logic [15:0] c, input logic [15:0] d,
                                             input dmo_pkg::dmo_op_t k);
        logic signed [31:0] pr;
        logic [39:0]        ext;
        pr = $signed(c) * $signed(d);
        ext = {{8{pr[31]}}, pr};
        return (k == dmo_pkg::OP_MPY) ? ext : (k == dmo_pkg::OP_MAC) ? old + ext : old - ext;
    endfunction : acc_next

    ////////////////////////////////////////////////////////////////
    // Drivers: one request per falling edge, notes queued in order
    task automatic load(input int idx, input logic [23:0] d);
        op_valid = 1'b0;
        ptr_wr = 1'b1;
        widx = 4'(idx);
        wdata = d;
        if (idx < 9) begin
            p[idx] = d;
        end
        @(negedge clk);
    endtask : load

    task automatic op(input logic [2:0] fs, ss, input logic [23:0] fst, sst, cst, input dmo_pkg::dmo_op_t k);
        dmo_note_t n;
        check("coefficient pointer", cptr, p[8]);
        n.refused = arms | (p[8] >= `DMO_INT_MEM_TOP);
        n.fa = p[fs];
        n.sa = p[ss];
        n.ca = p[8];
        if (!n.refused) begin
            m0 = acc_next(m0, mem.word(n.ca, 2'h0), mem.word(n.fa, 2'h1), k);
            m1 = acc_next(m1, mem.word(n.ca, 2'h0), mem.word(n.sa, 2'h2), k);
            p[fs] += fst;
            p[ss] += sst;
            p[8] += cst;
        end
        n.a0 = m0;
        n.a1 = m1;
        q.push_back(n);
        ptr_wr = 1'b0;
        op_valid = 1'b1;
        {fsel, ssel, fstep, sstep, cstep} = {fs, ss, fst, sst, cst};
        kind = k;
        @(negedge clk);
    endtask : op

    task automatic rand_op;
        op(3'($urandom % 8), 3'($urandom % 8), 24'($urandom % 4), 24'($urandom % 4), 24'($urandom % 2),
           dmo_pkg::dmo_op_t'($urandom % 3));
    endtask : rand_op

    ////////////////////////////////////////////////////////////////
    // Monitor: results first, then strobes of the next request
    always @(negedge clk) begin
        if (!rst && res_v) begin
            if (q.size() == 0 || q[0].refused) begin
                check("result without request", 40'h1, 40'h0);
            end else begin
                check("accumulator 0", acc0, q[0].a0);
                check("accumulator 1", acc1, q[0].a1);
                check("pair store alignment", 40'(st_addr[0]), 40'h0);
                st_addr = st_addr + 24'h2;
                void'(q.pop_front());
            end
        end
        if (!rst && (c_rd | f_rd | s_rd | refused)) begin
            if (q.size() == 0) begin
                check("strobe without request", 40'h1, 40'h0);
            end else begin
                check("refusal", refused, q[0].refused);
                check("strobes", {c_rd, f_rd, s_rd}, {3{~q[0].refused}});
                if (!q[0].refused) begin
                    check("first address", f_addr, q[0].fa);
                    check("second address", s_addr, q[0].sa);
                    check("coefficient address", c_addr, q[0].ca);
                end else begin
                    void'(q.pop_front());
                end
            end
        end
    end

    initial begin
        #50000ns;
        miscompares++;
        report_and_stop();
    end

    initial begin
        void'($urandom(54));
        repeat (2) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check("idle strobes", {c_rd, f_rd, s_rd, res_v, refused}, 40'h0);
        check("idle state", {acc0[15:0], cptr}, 40'h0);
        for (int i = 0; i < 16; i++) begin
            load(i, (i == 8) ? 24'($urandom % 24'h040000) : 24'($urandom));
        end
        repeat (60) rand_op();
        arms = 1'b1;
        rand_op();
        rand_op();
        arms = 1'b0;
        rand_op();
        load(8, `DMO_INT_MEM_TOP - 24'h1);
        op(3'h2, 3'h2, 24'h1, 24'h1, 24'h1, dmo_pkg::OP_MAS);
        op(3'h7, 3'h0, 24'h1, 24'h1, 24'h1, dmo_pkg::OP_MAC);
        load(8, 24'h0);
        op(3'h0, 3'h7, 24'h1, 24'h1, 24'h1, dmo_pkg::OP_MAC);
        op_valid = 1'b0;
        ptr_wr = 1'b0;
        repeat (4) @(negedge clk);
        check("notes left", 40'(q.size()), 40'h0);
        check("external shared reads", 40'(mem.ext_hits), 40'h0);
        report_and_stop();
    end
endmodule : test_dual_mac_operand_routing
